// ### hdl/sssx_regs.svh
// opcodes, pointer locations, cycle and byte counts, reset values
// How it works
// - one-byte opcode dfh forces carry to one in 4 cycles, other flags kept
// - opcodes d0h/d1h shift the operand right arithmetically, two bytes, 4 cycles
// - bit 7 stays and copies into bit 6, lower bits move down, bit 0 to carry
// - shift sets carry, zero and sign, clears overflow, keeps decimal and half flags
// - opcode 31h loads pointers from a two-byte immediate in 4 cycles, flags kept
// - low bits 10 load first pointer bits 3-7, 01 load second pointer bits 3-7
// - low bits 00 load bits 4-7 of both; first bit 3 cleared, second set
// - first pointer lives at location d6h, second at d7h
// - one-byte opcode 7fh takes 4 cycles, then halts cpu and system clocks
// - while stopped, every held register except the int_sync interrupt synchronizer keeps its value
// - stop ends only by external reset or external interrupt request
// - subtract writes destination minus source, source kept, sets zero and sign
// - subtract adds the inverted source plus one; 22h takes 4 cycles, 23h-26h take 6
// - subtract sets carry on borrow, clears it otherwise, sets decimal flag to one
// - overflow set when operand signs differ and result sign equals source sign
// - half flag cleared on carry out of bit 3, set otherwise
// - swap exchanges the low and high nibbles of the destination
// - swap sets zero and sign from result, keeps decimal and half flags
// - swap opcodes f0h and f1h are two bytes and 4 cycles
`ifndef SSSX_REGS_SVH
`define SSSX_REGS_SVH
`define SSSX_OPC_CARRY 8'hdf
`define SSSX_OPC_ASR_DIR 8'hd0
`define SSSX_OPC_ASR_IND 8'hd1
`define SSSX_OPC_PTR 8'h31
`define SSSX_OPC_STOP 8'h7f
`define SSSX_OPC_SUB_RR 8'h22
`define SSSX_OPC_SUB_RIR 8'h23
`define SSSX_OPC_SUB_GG 8'h24
`define SSSX_OPC_SUB_GIG 8'h25
`define SSSX_OPC_SUB_IMM 8'h26
`define SSSX_OPC_SWAP_DIR 8'hf0
`define SSSX_OPC_SWAP_IND 8'hf1
`define SSSX_CYC_SHORT 3'h4
`define SSSX_CYC_LONG 3'h6
`define SSSX_BYTES_ONE 2'h1
`define SSSX_BYTES_TWO 2'h2
`define SSSX_BYTES_THREE 2'h3
`define SSSX_ADDR_PTR_A 8'hd6
`define SSSX_ADDR_PTR_B 8'hd7
`define SSSX_SEL_A 2'h2
`define SSSX_SEL_B 2'h1
`define SSSX_SEL_BOTH 2'h0
`define SSSX_RST_PTR 8'h00
`define SSSX_RST_FLAGS 6'h00
`endif

// ### hdl/sssx_pkg.sv
// types shared by the executor and its arithmetic unit
package sssx_pkg;
  typedef enum logic [3:0] {
    SSSX_IDLE = 4'h1,
    SSSX_EXEC = 4'h2,
    SSSX_STOP = 4'h4,
    SSSX_WAKE = 4'h8
  } sssx_fsm_t;
  typedef enum logic [2:0] {
    SSSX_K_NONE, SSSX_K_CARRY, SSSX_K_ASR, SSSX_K_PTR, SSSX_K_STOP, SSSX_K_SUB, SSSX_K_SWAP
  } sssx_kind_t;
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } sssx_flags_t;
  typedef struct packed {
    sssx_fsm_t fsm;
    logic [2:0] cnt;
    sssx_kind_t kind;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] addr;
    logic [1:0] bytes;
    logic [1:0] int_sync;
    sssx_flags_t flags;
    logic [7:0] ptr_a;
    logic [7:0] ptr_b;
    logic [7:0] res;
    logic bad;
  } sssx_state_t;
endpackage

// ### hdl/sssx_alu_if.sv
// operand and result bundle between executor and arithmetic unit
`timescale 1ns/10ps
interface sssx_alu_if;
  sssx_pkg::sssx_kind_t kind;
  logic [7:0] dst;
  logic [7:0] src;
  sssx_pkg::sssx_flags_t flags_in;
  sssx_pkg::sssx_flags_t flags_out;
  logic [7:0] ptr_a_in;
  logic [7:0] ptr_b_in;
  logic [7:0] ptr_a_out;
  logic [7:0] ptr_b_out;
  logic [7:0] result;
  logic wr_dst;
  modport exec (
    output kind, dst, src, flags_in, ptr_a_in, ptr_b_in,
    input flags_out, ptr_a_out, ptr_b_out, result, wr_dst
  );
  modport alu (
    input kind, dst, src, flags_in, ptr_a_in, ptr_b_in,
    output flags_out, ptr_a_out, ptr_b_out, result, wr_dst
  );
endinterface

// ### hdl/sssx_alu.sv
// datapath results and flag updates for each instruction kind
`timescale 1ns/10ps
`include "sssx_regs.svh"
module sssx_alu (
  // operands in, results out
  sssx_alu_if.alu bus
);
  import sssx_pkg::*;
  logic [8:0] diff;
  logic [4:0] low;
  always_comb begin
    diff = {1'b0, bus.dst} + {1'b0, ~bus.src} + 9'h001;
    low = {1'b0, bus.dst[3:0]} + {1'b0, ~bus.src[3:0]} + 5'h01;
    bus.result = bus.dst;
    bus.flags_out = bus.flags_in;
    bus.ptr_a_out = bus.ptr_a_in;
    bus.ptr_b_out = bus.ptr_b_in;
    bus.wr_dst = 1'b0;
    unique case (bus.kind)
      SSSX_K_CARRY: begin
        bus.flags_out.c = 1'b1;
      end
      SSSX_K_ASR: begin
        bus.result = {bus.dst[7], bus.dst[7:1]};
        bus.flags_out.c = bus.dst[0];
        bus.flags_out.z = ({bus.dst[7], bus.dst[7:1]} == 8'h00);
        bus.flags_out.s = bus.dst[7];
        bus.flags_out.v = 1'b0;
        bus.wr_dst = 1'b1;
      end
      SSSX_K_PTR: begin
        unique case (bus.src[1:0])
          `SSSX_SEL_A: bus.ptr_a_out = {bus.src[7:3], bus.ptr_a_in[2:0]};
          `SSSX_SEL_B: bus.ptr_b_out = {bus.src[7:3], bus.ptr_b_in[2:0]};
          `SSSX_SEL_BOTH: begin
            bus.ptr_a_out = {bus.src[7:4], 1'b0, bus.ptr_a_in[2:0]};
            bus.ptr_b_out = {bus.src[7:4], 1'b1, bus.ptr_b_in[2:0]};
          end
          default: begin
            bus.ptr_a_out = bus.ptr_a_in;
          end
        endcase
      end
      SSSX_K_SUB: begin
        bus.result = diff[7:0];
        bus.flags_out.c = ~diff[8];
        bus.flags_out.z = (diff[7:0] == 8'h00);
        bus.flags_out.s = diff[7];
        bus.flags_out.v = (bus.dst[7] != bus.src[7]) && (diff[7] == bus.src[7]);
        bus.flags_out.d = 1'b1;
        bus.flags_out.h = ~low[4];
        bus.wr_dst = 1'b1;
      end
      SSSX_K_SWAP: begin
        bus.result = {bus.dst[3:0], bus.dst[7:4]};
        bus.flags_out.z = (bus.dst == 8'h00);
        bus.flags_out.s = bus.dst[3];
        bus.wr_dst = 1'b1;
      end
      SSSX_K_NONE, SSSX_K_STOP: begin
        bus.wr_dst = 1'b0;
      end
    endcase
  end
endmodule

// ### hdl/sssx_exec.sv
// executor for carry force, shift, pointer load, stop, subtract and swap
`timescale 1ns/10ps
`include "sssx_regs.svh"
module sssx_exec (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // instruction request from the fetch path
  input wire logic ins_valid,
  input wire logic [7:0] ins_opcode,
  input wire logic [7:0] ins_dst_addr,
  input wire logic [7:0] ins_dst_val,
  input wire logic [7:0] ins_src_val,
  output logic ins_ready,
  output logic ins_done,
  output logic [1:0] ins_bytes,
  output logic op_unknown,
  // register file write back
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // flags and pointers
  output sssx_pkg::sssx_flags_t flags,
  output logic [7:0] work_pointer_a,
  output logic [7:0] work_pointer_b,
  // stop mode and wake
  input wire logic ext_int_req,
  output logic stop_mode,
  output logic cpu_clk_run,
  output logic sys_clk_run
);
  import sssx_pkg::*;

  sssx_state_t st_ff;
  sssx_state_t nxt_st;
  sssx_kind_t dec_kind;
  logic [2:0] dec_cyc;
  logic [1:0] dec_bytes;
  sssx_alu_if alu_bus ();

  sssx_alu u_alu (
    .bus(alu_bus)
  );

  assign alu_bus.kind = st_ff.kind;
  assign alu_bus.dst = st_ff.dst;
  assign alu_bus.src = st_ff.src;
  assign alu_bus.flags_in = st_ff.flags;
  assign alu_bus.ptr_a_in = st_ff.ptr_a;
  assign alu_bus.ptr_b_in = st_ff.ptr_b;

  // opcode decode into kind, cycle count and length
  always_comb begin
    dec_kind = SSSX_K_NONE;
    dec_cyc = `SSSX_CYC_SHORT;
    dec_bytes = `SSSX_BYTES_TWO;
    unique case (ins_opcode)
      `SSSX_OPC_CARRY: begin
        dec_kind = SSSX_K_CARRY;
        dec_bytes = `SSSX_BYTES_ONE;
      end
      `SSSX_OPC_ASR_DIR, `SSSX_OPC_ASR_IND: begin
        dec_kind = SSSX_K_ASR;
      end
      `SSSX_OPC_PTR: begin
        dec_kind = SSSX_K_PTR;
      end
      `SSSX_OPC_STOP: begin
        dec_kind = SSSX_K_STOP;
        dec_bytes = `SSSX_BYTES_ONE;
      end
      `SSSX_OPC_SUB_RR: begin
        dec_kind = SSSX_K_SUB;
      end
      `SSSX_OPC_SUB_RIR: begin
        dec_kind = SSSX_K_SUB;
        dec_cyc = `SSSX_CYC_LONG;
      end
      `SSSX_OPC_SUB_GG, `SSSX_OPC_SUB_GIG, `SSSX_OPC_SUB_IMM: begin
        dec_kind = SSSX_K_SUB;
        dec_cyc = `SSSX_CYC_LONG;
        dec_bytes = `SSSX_BYTES_THREE;
      end
      `SSSX_OPC_SWAP_DIR, `SSSX_OPC_SWAP_IND: begin
        dec_kind = SSSX_K_SWAP;
      end
      default: begin
        dec_kind = SSSX_K_NONE;
      end
    endcase
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.int_sync = {st_ff.int_sync[0], ext_int_req};
    nxt_st.bad = 1'b0;
    unique case (st_ff.fsm)
      SSSX_IDLE: begin
        if (ins_valid) begin
          if (dec_kind == SSSX_K_NONE) begin
            nxt_st.bad = 1'b1;
          end else begin
            nxt_st.fsm = SSSX_EXEC;
            nxt_st.kind = dec_kind;
            nxt_st.cnt = dec_cyc - 3'h1;
            nxt_st.bytes = dec_bytes;
            nxt_st.dst = ins_dst_val;
            nxt_st.src = ins_src_val;
            nxt_st.addr = ins_dst_addr;
          end
        end
      end
      SSSX_EXEC: begin
        nxt_st.res = alu_bus.result;
        if (st_ff.cnt != 3'h0) begin
          nxt_st.cnt = st_ff.cnt - 3'h1;
        end else begin
          nxt_st.flags = alu_bus.flags_out;
          nxt_st.ptr_a = alu_bus.ptr_a_out;
          nxt_st.ptr_b = alu_bus.ptr_b_out;
          if (alu_bus.wr_dst && st_ff.addr == `SSSX_ADDR_PTR_A) begin
            nxt_st.ptr_a = st_ff.res;
          end
          if (alu_bus.wr_dst && st_ff.addr == `SSSX_ADDR_PTR_B) begin
            nxt_st.ptr_b = st_ff.res;
          end
          if (st_ff.kind == SSSX_K_STOP) begin
            nxt_st.fsm = SSSX_STOP;
          end else begin
            nxt_st.fsm = SSSX_IDLE;
          end
        end
      end
      SSSX_STOP: begin
        if (st_ff.int_sync[1]) begin
          nxt_st.fsm = SSSX_WAKE;
        end
      end
      SSSX_WAKE: begin
        nxt_st.fsm = SSSX_IDLE;
      end
    endcase
  end

  // register the state; reset is also the other exit from stop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.fsm <= SSSX_IDLE;
      st_ff.kind <= SSSX_K_NONE;
      st_ff.flags <= `SSSX_RST_FLAGS;
      st_ff.ptr_a <= `SSSX_RST_PTR;
      st_ff.ptr_b <= `SSSX_RST_PTR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ins_ready = (st_ff.fsm == SSSX_IDLE);
  assign ins_done = (st_ff.fsm == SSSX_EXEC) && (st_ff.cnt == 3'h0);
  assign ins_bytes = st_ff.bytes;
  assign op_unknown = st_ff.bad;
  assign wr_en = ins_done && alu_bus.wr_dst;
  assign wr_addr = st_ff.addr;
  assign wr_data = st_ff.res;
  assign flags = st_ff.flags;
  assign work_pointer_a = st_ff.ptr_a;
  assign work_pointer_b = st_ff.ptr_b;
  assign stop_mode = (st_ff.fsm == SSSX_STOP);
  assign cpu_clk_run = (st_ff.fsm != SSSX_STOP);
  assign sys_clk_run = (st_ff.fsm != SSSX_STOP);

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = ins_ready && ins_valid;

  carry_force_a: assert property (
    ins_done && st_ff.kind == SSSX_K_CARRY |=> flags.c &&
      {flags.z, flags.s, flags.v, flags.d, flags.h} ==
      $past({st_ff.flags.z, st_ff.flags.s, st_ff.flags.v, st_ff.flags.d, st_ff.flags.h}))
    else $error("carry force changed the wrong flags");

  short_cycles_a: assert property (
    take && (ins_opcode == `SSSX_OPC_CARRY || ins_opcode == `SSSX_OPC_ASR_DIR ||
      ins_opcode == `SSSX_OPC_ASR_IND || ins_opcode == `SSSX_OPC_PTR ||
      ins_opcode == `SSSX_OPC_SWAP_DIR || ins_opcode == `SSSX_OPC_SUB_RR)
      |=> !ins_done [*3] ##1 ins_done)
    else $error("short instruction did not take four cycles");

  long_cycles_a: assert property (
    take && ins_opcode inside {`SSSX_OPC_SUB_RIR, `SSSX_OPC_SUB_GG, `SSSX_OPC_SUB_GIG,
      `SSSX_OPC_SUB_IMM}
      |=> !ins_done [*5] ##1 ins_done)
    else $error("long subtract did not take six cycles");

  shift_result_a: assert property (
    ins_done && st_ff.kind == SSSX_K_ASR |-> wr_en &&
      wr_data == {st_ff.dst[7], st_ff.dst[7:1]})
    else $error("arithmetic shift result wrong");

  shift_flags_a: assert property (
    ins_done && st_ff.kind == SSSX_K_ASR |=> flags.c == $past(st_ff.dst[0]) && !flags.v &&
      flags.d == $past(st_ff.flags.d) && flags.h == $past(st_ff.flags.h) &&
      flags.z == ($past(wr_data) == 8'h00))
    else $error("arithmetic shift flags wrong");

  ptr_single_a: assert property (
    ins_done && st_ff.kind == SSSX_K_PTR && st_ff.src[1:0] == `SSSX_SEL_A |=>
      work_pointer_a[7:3] == $past(st_ff.src[7:3]) && $stable(work_pointer_b))
    else $error("first pointer load wrong");

  ptr_both_a: assert property (
    ins_done && st_ff.kind == SSSX_K_PTR && st_ff.src[1:0] == `SSSX_SEL_BOTH |=>
      work_pointer_a[7:3] == {$past(st_ff.src[7:4]), 1'b0} &&
      work_pointer_b[7:3] == {$past(st_ff.src[7:4]), 1'b1} && $stable(flags))
    else $error("dual pointer load wrong");

  ptr_keep_a: assert property (
    ins_done && st_ff.kind == SSSX_K_PTR && st_ff.src[1:0] == 2'h3 |=>
      $stable(work_pointer_a) && $stable(work_pointer_b))
    else $error("pointer load with both bits set changed a pointer");

  ptr_map_a: assert property (
    wr_en && wr_addr == `SSSX_ADDR_PTR_A |=> work_pointer_a == $past(wr_data))
    else $error("write to first pointer location lost");

  stop_hold_a: assert property (
    stop_mode |=> $stable(flags) && $stable(work_pointer_a) && $stable(work_pointer_b) &&
      !cpu_clk_run == stop_mode)
    else $error("state changed during stop");

  stop_exit_a: assert property (
    stop_mode && !st_ff.int_sync[1] |=> stop_mode)
    else $error("stop left without reset or interrupt");

  wake_order_a: assert property (
    $fell(stop_mode) |-> cpu_clk_run && sys_clk_run && !ins_ready ##1 ins_ready)
    else $error("wake did not restart clocks before resuming");

  sub_result_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SUB |-> wr_en &&
      wr_data == 8'(st_ff.dst - st_ff.src))
    else $error("subtract result wrong");

  sub_flags_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SUB |=> flags.d &&
      flags.c == ($past(st_ff.src) > $past(st_ff.dst)) &&
      flags.h == ($past(st_ff.src[3:0]) > $past(st_ff.dst[3:0])))
    else $error("subtract carry, decimal or half flag wrong");

  sub_ovf_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SUB |=> flags.v ==
      ($past(st_ff.dst[7]) != $past(st_ff.src[7]) && $past(wr_data[7]) == $past(st_ff.src[7])))
    else $error("subtract overflow wrong");

  swap_result_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SWAP |-> wr_en &&
      wr_data == {st_ff.dst[3:0], st_ff.dst[7:4]})
    else $error("swap result wrong");

  swap_flags_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SWAP |=> flags.s == $past(wr_data[7]) &&
      flags.d == $past(st_ff.flags.d) && flags.h == $past(st_ff.flags.h))
    else $error("swap flags wrong");

  ptr_second_a: assert property (
    ins_done && st_ff.kind == SSSX_K_PTR && st_ff.src[1:0] == `SSSX_SEL_B |=>
      work_pointer_b[7:3] == $past(st_ff.src[7:3]) && $stable(work_pointer_a))
    else $error("second pointer load wrong");

  ptr_flags_a: assert property (
    ins_done && st_ff.kind == SSSX_K_PTR |-> !wr_en ##1 $stable(flags))
    else $error("pointer load wrote a register or changed flags");

  ptr_map_b_a: assert property (
    wr_en && wr_addr == `SSSX_ADDR_PTR_B |=> work_pointer_b == $past(wr_data))
    else $error("write to second pointer location lost");

  carry_nowrite_a: assert property (
    ins_done && st_ff.kind == SSSX_K_CARRY |-> !wr_en)
    else $error("carry force wrote a register");

  stop_enter_a: assert property (
    ins_done && st_ff.kind == SSSX_K_STOP |-> !wr_en ##1
      stop_mode && !cpu_clk_run && !sys_clk_run && $stable(flags))
    else $error("stop did not halt the clocks cleanly");

  stop_cycles_a: assert property (
    take && ins_opcode == `SSSX_OPC_STOP |=> !ins_done [*3] ##1 ins_done ##1 stop_mode)
    else $error("stop did not take four cycles");

  stop_regs_a: assert property (
    stop_mode |=> $stable(wr_data) && $stable(wr_addr) && $stable(ins_bytes))
    else $error("result registers changed during stop");

  wake_hold_a: assert property (
    stop_mode && st_ff.int_sync[1] |=> !stop_mode && !ins_ready)
    else $error("interrupt wake skipped the restart cycle");

  one_byte_a: assert property (
    take && ins_opcode inside {`SSSX_OPC_CARRY, `SSSX_OPC_STOP} |=>
      ins_bytes == `SSSX_BYTES_ONE)
    else $error("one-byte instruction has wrong length");

  two_byte_a: assert property (
    take && ins_opcode inside {`SSSX_OPC_ASR_DIR, `SSSX_OPC_ASR_IND, `SSSX_OPC_PTR,
      `SSSX_OPC_SWAP_DIR, `SSSX_OPC_SWAP_IND, `SSSX_OPC_SUB_RR, `SSSX_OPC_SUB_RIR} |=>
      ins_bytes == `SSSX_BYTES_TWO)
    else $error("two-byte instruction has wrong length");

  three_byte_a: assert property (
    take && ins_opcode inside {`SSSX_OPC_SUB_GG, `SSSX_OPC_SUB_GIG, `SSSX_OPC_SUB_IMM} |=>
      ins_bytes == `SSSX_BYTES_THREE)
    else $error("three-byte subtract has wrong length");

  swap_cycles_a: assert property (
    take && ins_opcode inside {`SSSX_OPC_SWAP_DIR, `SSSX_OPC_SWAP_IND} |=>
      !ins_done [*3] ##1 ins_done)
    else $error("swap did not take four cycles");

  shift_sign_a: assert property (
    ins_done && st_ff.kind == SSSX_K_ASR |=> flags.s == $past(st_ff.dst[7]))
    else $error("arithmetic shift sign wrong");

  sub_zero_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SUB |=>
      flags.z == ($past(wr_data) == 8'h00) && flags.s == $past(wr_data[7]))
    else $error("subtract zero or sign wrong");

  sub_twos_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SUB |->
      wr_data == 8'(st_ff.dst + ~st_ff.src + 8'h01))
    else $error("subtract is not an add of the two's complement");

  swap_zero_a: assert property (
    ins_done && st_ff.kind == SSSX_K_SWAP |=> flags.z == ($past(wr_data) == 8'h00))
    else $error("swap zero flag wrong");

  stop_entry_c: cover property (take && ins_opcode == `SSSX_OPC_STOP ##[4:8] stop_mode);
  wake_c: cover property (stop_mode ##1 st_ff.int_sync[1] ##[1:3] ins_ready);
  sub_borrow_c: cover property (ins_done && st_ff.kind == SSSX_K_SUB ##1 flags.c && flags.v);
  ptr_both_c: cover property (ins_done && st_ff.kind == SSSX_K_PTR && st_ff.src[1:0] == 2'h0);
  shift_c: cover property (ins_done && st_ff.kind == SSSX_K_ASR && st_ff.dst[0]);
endmodule

// ### testbench/sssx_fetch_model.sv
// fetch path stand-in: offers one instruction and holds it until taken
`timescale 1ns/10ps
module sssx_fetch_model (
  // clock
  input wire logic mclk,
  // request to the executor
  input wire logic ins_ready,
  output logic ins_valid,
  output logic [7:0] ins_opcode,
  output logic [7:0] ins_dst_addr,
  output logic [7:0] ins_dst_val,
  output logic [7:0] ins_src_val
);
  initial begin
    ins_valid = 1'b0;
    ins_opcode = 8'h00;
    ins_dst_addr = 8'h00;
    ins_dst_val = 8'h00;
    ins_src_val = 8'h00;
  end
  // entered 10 ns after an edge; returns 10 ns after the taking edge
  task automatic issue(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] s);
    ins_valid = 1'b1;
    ins_opcode = op;
    ins_dst_addr = a;
    ins_dst_val = d;
    ins_src_val = s;
    while (ins_ready !== 1'b1) begin
      @(posedge mclk);
      #10;
    end
    @(posedge mclk);
    #10;
    // released lines show the inverse so stale values cannot pass
    ins_valid = 1'b0;
    ins_opcode = ~op;
    ins_dst_addr = ~a;
    ins_dst_val = ~d;
    ins_src_val = ~s;
  endtask
endmodule

// ### testbench/sssx_exec_bench.sv
// self-checking bench for the instruction executor
`timescale 1ns/10ps
module sssx_exec_bench;
  import sssx_pkg::*;
  logic mclk, rst_n, ext_int_req, ins_valid, ins_ready, ins_done, op_unknown, wr_en;
  logic stop_mode, cpu_clk_run, sys_clk_run, ewe;
  logic [7:0] ins_opcode, ins_dst_addr, ins_dst_val, ins_src_val, wr_addr, wr_data;
  logic [7:0] pa, pb, ea, eb, er;
  logic [1:0] ins_bytes;
  logic [15:0] nd, nb;
  logic [31:0] r, q;
  sssx_flags_t flags, ef;
  int fail_count, n_tests, seed, k;
  logic [7:0] ops [12] = '{8'hdf, 8'hd0, 8'hd1, 8'h31, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
                           8'hf0, 8'hf1, 8'h31};

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  sssx_exec dut (
    .mclk(mclk), .rst_n(rst_n), .ins_valid(ins_valid), .ins_opcode(ins_opcode),
    .ins_dst_addr(ins_dst_addr), .ins_dst_val(ins_dst_val), .ins_src_val(ins_src_val),
    .ins_ready(ins_ready), .ins_done(ins_done), .ins_bytes(ins_bytes),
    .op_unknown(op_unknown), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .flags(flags), .work_pointer_a(pa), .work_pointer_b(pb), .ext_int_req(ext_int_req),
    .stop_mode(stop_mode), .cpu_clk_run(cpu_clk_run), .sys_clk_run(sys_clk_run)
  );

  sssx_fetch_model fm (
    .mclk(mclk), .ins_ready(ins_ready), .ins_valid(ins_valid), .ins_opcode(ins_opcode),
    .ins_dst_addr(ins_dst_addr), .ins_dst_val(ins_dst_val), .ins_src_val(ins_src_val)
  );

  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #10;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected result, flags, pointers, length and cycle count
  function automatic void calc(input logic [7:0] op, input logic [7:0] a,
                               input logic [7:0] d, input logic [7:0] s);
    nb = 16'h2;
    nd = 16'h4;
    ewe = 1'b1;
    er = d;
    case (op)
      8'hdf: begin
        ef.c = 1'b1;
        ewe = 1'b0;
        nb = 16'h1;
      end
      8'hd0, 8'hd1: begin
        er = {d[7], d[7:1]};
        ef.c = d[0];
        ef.v = 1'b0;
      end
      8'h31: begin
        ewe = 1'b0;
        if (s[1:0] == 2'h2) ea[7:3] = s[7:3];
        if (s[1:0] == 2'h1) eb[7:3] = s[7:3];
        if (s[1:0] == 2'h0) begin
          ea = {s[7:4], 1'b0, ea[2:0]};
          eb = {s[7:4], 1'b1, eb[2:0]};
        end
      end
      8'h7f: begin
        ewe = 1'b0;
        nb = 16'h1;
      end
      8'hf0, 8'hf1: er = {d[3:0], d[7:4]};
      8'h22, 8'h23, 8'h24, 8'h25, 8'h26: begin
        er = d - s;
        ef.c = s > d;
        ef.v = (d[7] != s[7]) && (er[7] == s[7]);
        ef.d = 1'b1;
        ef.h = s[3:0] > d[3:0];
        if (op != 8'h22) nd = 16'h6;
        if (op > 8'h23) nb = 16'h3;
      end
      default: begin
        nd = 16'h0;
        ewe = 1'b0;
      end
    endcase
    if (ewe) begin
      ef.z = (er == 8'h00);
      ef.s = er[7];
      if (a == 8'hd6) ea = er;
      if (a == 8'hd7) eb = er;
    end
  endfunction

  task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] s);
    logic [15:0] n;
    calc(op, a, d, s);
    fm.issue(op, a, d, s);
    n = 16'h1;
    if (nd == 16'h0) begin
      chk(op_unknown, 16'h1);
      step(1);
    end else begin
      while (ins_done !== 1'b1 && n < 16'h8) begin
        step(1);
        n++;
      end
      chk(n, nd);
      chk(ins_bytes, nb);
      chk(wr_en, ewe);
      if (ewe) chk(wr_data, er);
      if (ewe) chk(wr_addr, a);
      step(1);
    end
    chk(flags, ef);
    chk(pa, ea);
    chk(pb, eb);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(100 * 8000);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    summarize;
  end

  initial begin
    seed = 41;
    rst_n = 1'b0;
    ext_int_req = 1'b0;
    ef = '0;
    ea = 8'h00;
    eb = 8'h00;
    fail_count = 0;
    n_tests = 0;
    step(8);
    rst_n = 1'b1;
    chk({stop_mode, cpu_clk_run, sys_clk_run, ins_ready}, 16'h7);
    chk(flags, ef);
    $display("test reset done");
    run(8'h22, 8'h01, 8'h12, 8'h03);
    run(8'h26, 8'h01, 8'h21, 8'h90);
    run(8'h26, 8'h01, 8'h21, 8'h65);
    run(8'h24, 8'h05, 8'h3c, 8'h3c);
    run(8'h25, 8'h05, 8'h80, 8'h01);
    run(8'hd0, 8'h00, 8'h9a, 8'h00);
    run(8'hd1, 8'h03, 8'hbc, 8'h00);
    run(8'hd0, 8'h03, 8'h01, 8'h00);
    run(8'hdf, 8'h00, 8'h00, 8'h00);
    run(8'h31, 8'h00, 8'h00, 8'h40);
    run(8'h31, 8'h00, 8'h00, 8'h52);
    run(8'h31, 8'h00, 8'h00, 8'h69);
    run(8'h31, 8'h00, 8'h00, 8'hfb);
    run(8'hf0, 8'h00, 8'h3e, 8'h00);
    run(8'hf1, 8'h03, 8'h00, 8'h00);
    run(8'h23, 8'hd6, 8'h50, 8'h01);
    run(8'hf0, 8'hd7, 8'ha4, 8'h00);
    run(8'h00, 8'h00, 8'h11, 8'h22);
    $display("test corners done");
    for (k = 0; k < 60; k++) begin
      r = $random(seed);
      q = $random(seed);
      run(ops[r[7:0] % 8'd12], r[8] ? {7'h6b, r[9]} : r[23:16], r[31:24], q[7:0]);
    end
    $display("test random done");
    run(8'h7f, 8'h00, 8'h00, 8'h00);
    chk({stop_mode, cpu_clk_run, sys_clk_run}, 16'h4);
    step(5);
    chk({stop_mode, ins_ready}, 16'h2);
    ext_int_req = 1'b1;
    step(3);
    chk({stop_mode, cpu_clk_run, sys_clk_run, ins_ready}, 16'h6);
    step(1);
    chk(ins_ready, 16'h1);
    ext_int_req = 1'b0;
    chk(flags, ef);
    chk({pa, pb}, {ea, eb});
    run(8'hdf, 8'h00, 8'h00, 8'h00);
    run(8'h7f, 8'h00, 8'h00, 8'h00);
    rst_n = 1'b0;
    step(8);
    rst_n = 1'b1;
    ef = '0;
    ea = 8'h00;
    eb = 8'h00;
    chk({stop_mode, ins_ready}, 16'h1);
    run(8'h22, 8'h01, 8'h00, 8'h01);
    $display("test stop done");
    summarize;
  end
endmodule
